//--- include/ued_regs.svh
`ifndef UED_REGS_SVH
`define UED_REGS_SVH
// ----------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define UED_IDX_SER_CTRL  8'h98
`define UED_IDX_RX_BUFFER 8'h99
`define UED_IDX_BAUD_TMR  8'h9e
`define UED_IDX_CFG       8'haf
`define UED_IDX_ISTAT     8'hc0
`define UED_IDX_IMASK     8'hc1
`define UED_IDX_DIV       8'hc2
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define UED_SC_NINE         7
`define UED_SC_STOP_CHECK   5
`define UED_SC_REN          4
`define UED_SC_TB8          3
`define UED_SC_NINTH_LATCH  2
`define UED_SC_TI           1
`define UED_SC_RX_DONE      0
`define UED_BT_FRAME_ERR  7
`define UED_BT_BREAK_ERR  6
`define UED_BT_OVW        5
`define UED_CFG_EXT       7
`define UED_CFG_CARR      6
`define UED_CFG_WAKE      5
`define UED_IS_RX         0
`define UED_IS_TX         1
`define UED_IS_FRAME      2
`define UED_IS_BREAK      3
`define UED_IS_OVW        4
`define UED_IS_WAKE       5
// ----------------------------------------------------------------
// reset values, responses, timing
// ----------------------------------------------------------------
`define UED_DIV_RST       16'h0057
`define UED_RESP_OKAY     2'h0
`define UED_RESP_SLVERR   2'h2
`define UED_FRAME9_BITS   20'h0000b
`define UED_RX_LAST8      4'h7
`define UED_RX_LAST9      4'h8
`define UED_TX_BITS8      4'ha
`define UED_TX_BITS9      4'hb
`define UED_CFG_MASK      8'he0
`define UED_CLK_HZ        10000000
`define UED_CARRIER_HZ    38000
`define UED_CARR_HALF     (`UED_CLK_HZ / (2 * `UED_CARRIER_HZ))
`endif

//--- include/ued_pkg.sv
package ued_pkg;
   // ----------------------------------------------------------------
   // receiver state
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      UED_RX_IDLE,
      UED_RX_START,
      UED_RX_DATA,
      UED_RX_STOP,
      UED_RX_WAIT_HIGH
   } ued_rx_state_t;

   typedef struct packed {
      ued_rx_state_t st;
      logic [15:0]   tmr;
      logic [3:0]    bitn;
      logic [8:0]    shift;
      logic [19:0]   low_cnt;
      logic          brk_done;
      logic          fr_v;
      logic [7:0]    fr_data;
      logic          fr_ninth;
      logic          fr_stop_ok;
      logic          brk_v;
   } ued_rx_st_t;

   typedef struct packed {
      logic [7:0] cnt;
      logic       wave;
   } ued_carr_st_t;

   // ----------------------------------------------------------------
   // top level state: bus slave, registers, transmitter
   // ----------------------------------------------------------------
   typedef struct packed {
      logic        aw_have;
      logic [7:0]  aw_idx;
      logic        w_have;
      logic [31:0] w_data;
      logic [3:0]  w_strb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic [7:0]  ser_ctrl;
      logic [7:0]  rx_buffer;
      logic [7:0]  baud_tmr;
      logic [7:0]  cfg;
      logic [7:0]  istat;
      logic [7:0]  imask;
      logic [15:0] div;
      logic        tx_busy;
      logic [10:0] tx_shift;
      logic [3:0]  tx_cnt;
      logic [15:0] tx_tmr;
      logic        txd;
      logic        rxd_prev;
      logic        wake;
      logic        irq;
   } ued_top_st_t;
endpackage

//--- design/ued_rx.sv
`timescale 1ns/1ns
`default_nettype none
`include "ued_regs.svh"
module ued_rx (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic        rxd_i,
   input  wire logic        en_i,
   input  wire logic        nine_i,
   input  wire logic [15:0] bit_cycles_i,
   output logic             frame_o,
   output logic [7:0]       data_o,
   output logic             ninth_o,
   output logic             stop_ok_o,
   output logic             break_o
);
   ued_pkg::ued_rx_st_t s_reg;
   ued_pkg::ued_rx_st_t s_next;
   logic [19:0]         frame_len;

   // length of one 9-bit frame in clock cycles
   assign frame_len = 20'({4'h0, bit_cycles_i} * `UED_FRAME9_BITS);

   // frame sampler and low-run watch
   always_comb begin
      s_next = s_reg;
      s_next.fr_v = 1'b0;
      s_next.brk_v = 1'b0;
      if (rxd_i) begin
         s_next.low_cnt = 20'h00000;
         s_next.brk_done = 1'b0;
      end else if (s_reg.low_cnt != frame_len) begin
         s_next.low_cnt = s_reg.low_cnt + 20'h00001;
      end else if (!s_reg.brk_done) begin
         s_next.brk_v = 1'b1; // line low past a 9-bit frame
         s_next.brk_done = 1'b1;
      end
      if (s_reg.tmr != 16'h0000)
         s_next.tmr = s_reg.tmr - 16'h0001;
      case (s_reg.st)
         ued_pkg::UED_RX_IDLE: begin
            if (en_i && !rxd_i) begin
               s_next.st = ued_pkg::UED_RX_START;
               s_next.tmr = bit_cycles_i >> 1;
            end
         end
         ued_pkg::UED_RX_START: begin
            if (s_reg.tmr == 16'h0000) begin
               s_next.st = rxd_i ? ued_pkg::UED_RX_IDLE : ued_pkg::UED_RX_DATA;
               s_next.tmr = bit_cycles_i - 16'h0001;
               s_next.bitn = 4'h0;
            end
         end
         ued_pkg::UED_RX_DATA: begin
            if (s_reg.tmr == 16'h0000) begin
               s_next.shift = {rxd_i, s_reg.shift[8:1]};
               s_next.bitn = s_reg.bitn + 4'h1;
               s_next.tmr = bit_cycles_i - 16'h0001;
               if (s_reg.bitn == (nine_i ? `UED_RX_LAST9 : `UED_RX_LAST8))
                  s_next.st = ued_pkg::UED_RX_STOP;
            end
         end
         ued_pkg::UED_RX_STOP: begin
            if (s_reg.tmr == 16'h0000) begin
               s_next.fr_v = 1'b1;
               s_next.fr_data = nine_i ? s_reg.shift[7:0] : s_reg.shift[8:1];
               s_next.fr_ninth = nine_i ? s_reg.shift[8] : rxd_i;
               s_next.fr_stop_ok = rxd_i; // stop bit must be high
               s_next.st = rxd_i ? ued_pkg::UED_RX_IDLE : ued_pkg::UED_RX_WAIT_HIGH;
            end
         end
         ued_pkg::UED_RX_WAIT_HIGH: begin
            if (rxd_i)
               s_next.st = ued_pkg::UED_RX_IDLE;
         end
         default: s_next.st = ued_pkg::UED_RX_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign frame_o   = s_reg.fr_v;
   assign data_o    = s_reg.fr_data;
   assign ninth_o   = s_reg.fr_ninth;
   assign stop_ok_o = s_reg.fr_stop_ok;
   assign break_o   = s_reg.brk_v;
endmodule // ued_rx
`default_nettype wire

//--- design/ued_carrier.sv
`timescale 1ns/1ns
`default_nettype none
`include "ued_regs.svh"
module ued_carrier (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic en_i,
   output logic      wave_o
);
   localparam logic [7:0] HALF_M1 = 8'(`UED_CARR_HALF - 1);
   ued_pkg::ued_carr_st_t s_reg;
   ued_pkg::ued_carr_st_t s_next;

   // square wave near 38 kHz, held low while disabled
   always_comb begin
      s_next = s_reg;
      if (!en_i) begin
         s_next = '0;
      end else if (s_reg.cnt == HALF_M1) begin
         s_next.cnt = 8'h00;
         s_next.wave = !s_reg.wave; // carrier toggle
      end else begin
         s_next.cnt = s_reg.cnt + 8'h01;
      end
   end

   // state register
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i)
         s_reg <= '0;
      else
         s_reg <= s_next;
   end

   assign wave_o = s_reg.wave;
endmodule // ued_carrier
`default_nettype wire

//--- design/ued_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "ued_regs.svh"
module ued_top (
   input  wire logic        clk_i,
   input  wire logic        reset_i,
   input  wire logic [9:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [9:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        rxd_i,
   output logic             txd_o,
   output logic             wake_o,
   output logic             irq_o
);
   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   ued_pkg::ued_top_st_t s_reg;
   ued_pkg::ued_top_st_t s_next;
   logic                 rx_frame;
   logic [7:0]           rx_data;
   logic                 rx_ninth;
   logic                 rx_stop_ok;
   logic                 rx_break;
   logic                 carrier;
   logic                 ext_on;
   logic                 nine_bit;
   logic                 aw_take;
   logic                 w_take;
   logic                 ar_take;
   logic                 wr_fire;
   logic                 accept;
   logic [7:0]           ev;

   // register index from a byte address
   function automatic logic [7:0] ued_idx(input logic [9:0] addr);
      ued_idx = addr[9:2];
   endfunction

   // whether an index names a register
   function automatic logic ued_mapped(input logic [7:0] idx);
      case (idx)
         `UED_IDX_SER_CTRL, `UED_IDX_RX_BUFFER, `UED_IDX_BAUD_TMR, `UED_IDX_CFG,
         `UED_IDX_ISTAT, `UED_IDX_IMASK, `UED_IDX_DIV: ued_mapped = 1'b1;
         default: ued_mapped = 1'b0;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // receiver and carrier
   // ----------------------------------------------------------------
   ued_rx u_rx (
      .clk_i        (clk_i),
      .reset_i      (reset_i),
      .rxd_i        (rxd_i),
      .en_i         (s_reg.ser_ctrl[`UED_SC_REN]),
      .nine_i       (nine_bit),
      .bit_cycles_i (s_reg.div),
      .frame_o      (rx_frame),
      .data_o       (rx_data),
      .ninth_o      (rx_ninth),
      .stop_ok_o    (rx_stop_ok),
      .break_o      (rx_break)
   );

   ued_carrier u_carrier (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .en_i    (s_reg.cfg[`UED_CFG_CARR]),
      .wave_o  (carrier)
   );

   // ----------------------------------------------------------------
   // handshakes and receive acceptance
   // ----------------------------------------------------------------
   // mode bits used in several places
   assign ext_on   = s_reg.cfg[`UED_CFG_EXT];
   assign nine_bit = s_reg.ser_ctrl[`UED_SC_NINE];

   // one write and one read at a time; ready drops while holding
   assign s_axi_awready = !s_reg.aw_have && !s_reg.bvalid;
   assign s_axi_wready  = !s_reg.w_have && !s_reg.bvalid;
   assign s_axi_arready = !s_reg.rvalid;
   assign aw_take = s_axi_awvalid && s_axi_awready;
   assign w_take  = s_axi_wvalid && s_axi_wready;
   assign ar_take = s_axi_arvalid && s_axi_arready;
   assign wr_fire = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;

   // frame acceptance: done flag blocks only in standard mode,
   // stop check drops frames whose ninth or stop bit is low
   always_comb begin
      accept = rx_frame;
      if (!ext_on && s_reg.ser_ctrl[`UED_SC_RX_DONE])
         accept = 1'b0; // frame lost, flag untouched
      if (s_reg.ser_ctrl[`UED_SC_STOP_CHECK] && !rx_ninth)
         accept = 1'b0; // missing stop or ninth bit dropped
   end

   // events feeding the sticky interrupt status
   always_comb begin
      ev = 8'h00;
      ev[`UED_IS_RX]   = accept;
      ev[`UED_IS_TX]   = s_reg.tx_busy && (s_reg.tx_tmr == 16'h0000) &&
                         (s_reg.tx_cnt == 4'h1);
      ev[`UED_IS_FRAME] = ext_on && rx_frame && !rx_stop_ok;
      ev[`UED_IS_BREAK] = ext_on && rx_break;
      ev[`UED_IS_OVW]  = ext_on && accept && s_reg.ser_ctrl[`UED_SC_RX_DONE];
      ev[`UED_IS_WAKE] = s_reg.cfg[`UED_CFG_WAKE] && s_reg.rxd_prev && !rxd_i;
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_next = s_reg;
      s_next.rxd_prev = rxd_i;

      // write address and data taken in either order
      if (aw_take) begin
         s_next.aw_have = 1'b1;
         s_next.aw_idx = ued_idx(s_axi_awaddr);
      end
      if (w_take) begin
         s_next.w_have = 1'b1;
         s_next.w_data = s_axi_wdata;
         s_next.w_strb = s_axi_wstrb;
      end
      if (s_reg.bvalid && s_axi_bready)
         s_next.bvalid = 1'b0;

      // register writes; software clears come before hardware sets
      if (wr_fire) begin
         s_next.aw_have = 1'b0;
         s_next.w_have = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = ued_mapped(s_reg.aw_idx) ? `UED_RESP_OKAY : `UED_RESP_SLVERR;
         if (s_reg.w_strb[0]) begin
            case (s_reg.aw_idx)
               `UED_IDX_SER_CTRL: s_next.ser_ctrl = s_reg.w_data[7:0];
               `UED_IDX_RX_BUFFER: begin
                  if (!s_reg.tx_busy) begin
                     s_next.tx_busy = 1'b1;
                     s_next.tx_cnt = nine_bit ? `UED_TX_BITS9 : `UED_TX_BITS8;
                     s_next.tx_tmr = s_reg.div - 16'h0001;
                     s_next.tx_shift = {1'b1,
                                        nine_bit ? s_reg.ser_ctrl[`UED_SC_TB8] : 1'b1,
                                        s_reg.w_data[7:0], 1'b0};
                  end
               end
               `UED_IDX_BAUD_TMR: begin
                  // flags are write-one-to-clear, low bits plain storage
                  s_next.baud_tmr[4:0] = s_reg.w_data[4:0];
                  s_next.baud_tmr[7:5] = s_reg.baud_tmr[7:5] & ~s_reg.w_data[7:5];
               end
               `UED_IDX_CFG: s_next.cfg = s_reg.w_data[7:0] & `UED_CFG_MASK;
               `UED_IDX_ISTAT: s_next.istat = s_reg.istat & ~s_reg.w_data[7:0];
               `UED_IDX_IMASK: s_next.imask = s_reg.w_data[7:0];
               `UED_IDX_DIV: s_next.div[7:0] = s_reg.w_data[7:0];
               default: s_next.imask = s_reg.imask;
            endcase
         end
         if (s_reg.w_strb[1] && s_reg.aw_idx == `UED_IDX_DIV)
            s_next.div[15:8] = s_reg.w_data[15:8];
      end

      // read channel: data latched at the address handshake
      if (s_reg.rvalid && s_axi_rready)
         s_next.rvalid = 1'b0;
      if (ar_take) begin
         s_next.rvalid = 1'b1;
         s_next.rresp = ued_mapped(ued_idx(s_axi_araddr)) ? `UED_RESP_OKAY
                                                           : `UED_RESP_SLVERR;
         case (ued_idx(s_axi_araddr))
            `UED_IDX_SER_CTRL: s_next.rdata = {24'h000000, s_reg.ser_ctrl};
            `UED_IDX_RX_BUFFER: begin
               s_next.rdata = {24'h000000, s_reg.rx_buffer};
               s_next.baud_tmr[`UED_BT_OVW] = 1'b0; // read clears overwrite
            end
            `UED_IDX_BAUD_TMR: s_next.rdata = {24'h000000, s_reg.baud_tmr};
            `UED_IDX_CFG:    s_next.rdata = {24'h000000, s_reg.cfg};
            `UED_IDX_ISTAT:  s_next.rdata = {24'h000000, s_reg.istat};
            `UED_IDX_IMASK:  s_next.rdata = {24'h000000, s_reg.imask};
            `UED_IDX_DIV:    s_next.rdata = {16'h0000, s_reg.div};
            default:         s_next.rdata = 32'h00000000;
         endcase
      end

      // transmitter: start, data, optional ninth, stop
      if (s_reg.tx_busy) begin
         if (s_reg.tx_tmr != 16'h0000) begin
            s_next.tx_tmr = s_reg.tx_tmr - 16'h0001;
         end else begin
            s_next.tx_tmr = s_reg.div - 16'h0001;
            s_next.tx_shift = {1'b1, s_reg.tx_shift[10:1]};
            s_next.tx_cnt = s_reg.tx_cnt - 4'h1;
            if (s_reg.tx_cnt == 4'h1) begin
               s_next.tx_busy = 1'b0;
               s_next.ser_ctrl[`UED_SC_TI] = 1'b1;
            end
         end
      end

      // accepted frame: hold byte, latch ninth or stop bit, flag done
      if (accept) begin
         s_next.rx_buffer = rx_data; // older byte overwritten
         s_next.ser_ctrl[`UED_SC_NINTH_LATCH] = rx_ninth; // stop bit in 8-bit format
         s_next.ser_ctrl[`UED_SC_RX_DONE] = 1'b1;
      end

      // error flags: hardware set wins over any clear this cycle
      if (ev[`UED_IS_FRAME])
         s_next.baud_tmr[`UED_BT_FRAME_ERR] = 1'b1;
      if (ev[`UED_IS_BREAK])
         s_next.baud_tmr[`UED_BT_BREAK_ERR] = 1'b1;
      if (ev[`UED_IS_OVW])
         s_next.baud_tmr[`UED_BT_OVW] = 1'b1;

      // sticky interrupt status and gated request
      s_next.istat = s_next.istat | ev;
      s_next.irq = |(s_next.istat & s_reg.imask);

      // registered line outputs
      s_next.wake = ev[`UED_IS_WAKE]; // falling receive edge wakes core
      s_next.txd = (s_reg.tx_busy ? s_reg.tx_shift[0] : 1'b1) |
                   (s_reg.cfg[`UED_CFG_CARR] & carrier);
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         s_reg <= '0;
         s_reg.div <= `UED_DIV_RST;
         s_reg.txd <= 1'b1;
         s_reg.rxd_prev <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs
   assign s_axi_bvalid = s_reg.bvalid;
   assign s_axi_bresp  = s_reg.bresp;
   assign s_axi_rvalid = s_reg.rvalid;
   assign s_axi_rdata  = s_reg.rdata;
   assign s_axi_rresp  = s_reg.rresp;
   assign txd_o        = s_reg.txd;
   assign wake_o       = s_reg.wake;
   assign irq_o        = s_reg.irq;
endmodule // ued_top
`default_nettype wire

//--- dv/ued_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// port checker
// ----------------------------------------------------------------
module ued_checker (
   input wire logic        clk_i,
   input wire logic        reset_i,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        rxd_i,
   input wire logic        wake_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   // bus answers stand and arrive in time
   AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
   AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
   AST_RANS: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_RBLK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while busy");
   AST_BANS: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
   AST_WBLK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
   // wake is one pulse caused by a low line
   AST_WPULSE: assert property (wake_o |=> !wake_o)
      else $error("wake pulse too long");
   AST_WCAUSE: assert property (wake_o |-> !$past(rxd_i) || !$past(rxd_i, 2))
      else $error("wake without line activity");
endmodule // ued_checker

bind ued_top ued_checker chk_u (
   .clk_i, .reset_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
   .s_axi_rready, .rxd_i, .wake_o
);
`default_nettype wire

//--- dv/ued_remote.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// remote serial transmitter on the receive line
// ----------------------------------------------------------------
module ued_remote #(
   parameter int BIT_CYC = 16
) (
   input  wire logic clk_i,
   output logic      line_o
);
   // line idles high
   initial line_o = 1'b1;
   // start, data lsb first, chosen stop level, then idle
   task automatic send(input logic [8:0] d, input int n, input logic stp);
      line_o <= 1'b0;
      repeat (BIT_CYC) @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
         line_o <= d[i];
         repeat (BIT_CYC) @(posedge clk_i);
      end
      line_o <= stp;
      repeat (BIT_CYC) @(posedge clk_i);
      line_o <= 1'b1;
      repeat (3 * BIT_CYC) @(posedge clk_i);
   endtask
   // line held low, then idle
   task automatic hold_low(input int c);
      line_o <= 1'b0;
      repeat (c) @(posedge clk_i);
      line_o <= 1'b1;
      repeat (3 * BIT_CYC) @(posedge clk_i);
   endtask
endmodule // ued_remote
`default_nettype wire

//--- dv/test_uart_error_detection.sv
`timescale 1ns/1ns
`default_nettype none
`include "ued_regs.svh"
module test_uart_error_detection;
   localparam int BITC = 16;
   logic        clk_i, reset_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
   logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
   logic        s_axi_arready, s_axi_rvalid, s_axi_rready, txd_o, wake_o, irq_o;
   logic [9:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   wire         rxd;
   int          fail_count, comparisons, wake_cnt, low_cnt, base;
   // ----------------------------------------------------------------
   // design and remote device
   // ----------------------------------------------------------------
   ued_top dut_u (.clk_i, .reset_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rxd_i(rxd),
      .txd_o, .wake_o, .irq_o);
   ued_remote #(.BIT_CYC(BITC)) rem_u (.clk_i, .line_o(rxd));
   // clock and pin monitors
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      wake_cnt <= wake_cnt + int'(wake_o);
      low_cnt <= low_cnt + int'(!txd_o);
   end
   // ----------------------------------------------------------------
   // checking and bus tasks
   // ----------------------------------------------------------------
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one clock with a bounded budget
   task automatic tick(inout int n);
      @(posedge clk_i);
      n++;
      if (n > 400) begin
         chk("bus wait", 32'h0, 32'h1);
         summarize();
      end
   endtask
   task automatic wr(input logic [7:0] idx, input logic [31:0] d);
      int n;
      logic a, w;
      n = 0;
      a = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (a || w) begin
         tick(n);
         if (s_axi_awready)
            a = 1'b0;
         if (s_axi_wready)
            w = 1'b0;
         s_axi_awvalid <= a;
         s_axi_wvalid <= w;
      end
      tick(n);
      tick(n);
      s_axi_bready <= 1'b1;
      tick(n);
      while (!s_axi_bvalid)
         tick(n);
      resp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] idx);
      int n;
      n = 0;
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      tick(n);
      while (!s_axi_arready)
         tick(n);
      s_axi_arvalid <= 1'b0;
      tick(n);
      s_axi_rready <= 1'b1;
      tick(n);
      while (!s_axi_rvalid)
         tick(n);
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      s_axi_rready <= 1'b0;
   endtask
   task automatic rdchk(input logic [7:0] idx, input logic [31:0] m, input logic [31:0] e,
                        input string nm);
      rd(idx);
      chk(nm, e, rdat & m);
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      reset_i = 1'b1;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_awaddr = '0;
      s_axi_araddr = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hf;
      repeat (12) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      rdchk(`UED_IDX_DIV, 32'hffffffff, {16'h0, `UED_DIV_RST}, "div reset");
      rd(8'h10);
      chk("unmapped resp", {30'h0, `UED_RESP_SLVERR}, {30'h0, resp});
      chk("unmapped data", 32'h0, rdat);
      wr(`UED_IDX_DIV, 32'(BITC));
      wr(`UED_IDX_CFG, 32'ha0);
      wr(`UED_IDX_IMASK, 32'h3f);
      wr(`UED_IDX_SER_CTRL, 32'h10);
      // extended mode: bad stop, then a byte over an unread one
      rem_u.send(9'h0a5, 8, 1'b0);
      rdchk(`UED_IDX_BAUD_TMR, 32'h80, 32'h80, "frame err 8");
      rdchk(`UED_IDX_SER_CTRL, 32'h04, 32'h00, "stop latch low");
      base = wake_cnt;
      rem_u.send(9'h0ff, 8, 1'b1);
      chk("wake pulses", 32'h1, 32'(wake_cnt - base));
      rdchk(`UED_IDX_SER_CTRL, 32'h04, 32'h04, "stop latch high");
      rdchk(`UED_IDX_BAUD_TMR, 32'ha0, 32'ha0, "sticky and overwrite");
      rdchk(`UED_IDX_RX_BUFFER, 32'hff, 32'hff, "overwritten byte");
      rdchk(`UED_IDX_BAUD_TMR, 32'h20, 32'h00, "overwrite cleared");
      wr(`UED_IDX_BAUD_TMR, 32'h80);
      rdchk(`UED_IDX_BAUD_TMR, 32'h80, 32'h00, "frame err cleared");
      // interrupt level, masking and clearing
      chk("irq on", 32'h1, {31'h0, irq_o});
      wr(`UED_IDX_IMASK, 32'h00);
      chk("irq masked", 32'h0, {31'h0, irq_o});
      wr(`UED_IDX_ISTAT, 32'hff);
      wr(`UED_IDX_IMASK, 32'h3f);
      chk("irq cleared", 32'h0, {31'h0, irq_o});
      // nine-bit frame without stop, then a long low line
      wr(`UED_IDX_SER_CTRL, 32'h90);
      rem_u.send(9'h1c3, 9, 1'b0);
      rdchk(`UED_IDX_BAUD_TMR, 32'h80, 32'h80, "frame err 9");
      rem_u.hold_low(13 * BITC);
      rdchk(`UED_IDX_BAUD_TMR, 32'h40, 32'h40, "break");
      wr(`UED_IDX_BAUD_TMR, 32'he0);
      // standard mode
      wr(`UED_IDX_CFG, 32'h20);
      wr(`UED_IDX_SER_CTRL, 32'h10);
      rem_u.send(9'h00f, 8, 1'b0);
      rdchk(`UED_IDX_RX_BUFFER, 32'hff, 32'h0f, "std accept");
      rdchk(`UED_IDX_BAUD_TMR, 32'h80, 32'h00, "no frame err std");
      rem_u.send(9'h077, 8, 1'b1);
      rdchk(`UED_IDX_RX_BUFFER, 32'hff, 32'h0f, "std drop");
      rdchk(`UED_IDX_BAUD_TMR, 32'h20, 32'h00, "no overwrite std");
      wr(`UED_IDX_SER_CTRL, 32'h30);
      rem_u.send(9'h055, 8, 1'b0);
      rdchk(`UED_IDX_RX_BUFFER, 32'hff, 32'h0f, "stop check drop");
      rdchk(`UED_IDX_SER_CTRL, 32'h01, 32'h00, "no done flag");
      // carrier on a long low transmit bit
      wr(`UED_IDX_CFG, 32'h40);
      wr(`UED_IDX_DIV, 32'h400);
      wr(`UED_IDX_RX_BUFFER, 32'h00);
      repeat (1024) @(posedge clk_i);
      base = low_cnt;
      repeat (8 * `UED_CARR_HALF) @(posedge clk_i);
      chk("carrier low", 32'(4 * `UED_CARR_HALF), 32'(low_cnt - base));
      summarize();
   end
endmodule // test_uart_error_detection
`default_nettype wire
